// File: design/timer_counter.sv
// Five-mode 16-bit up-counting timer/counter with AHB-Lite registers
// Functional notes
// - Five modes: timer, external trigger, event, window, pulse width.
// - 16-bit compare and capture registers, untouched by reset.
// - Timer mode counts internal clock; match interrupts, clears, continues.
// - Internal clock taps divide oscillator by 8, 128 or 2048.
// - Outside pulse and external trigger modes, soft capture bit copies live count to capture, then self-clears.
// - External trigger mode starts counting on selected pin edge.
// - External trigger match interrupts, clears, halts until next edge.
// - Pin filtered: pulses of seven periods or fewer rejected.
// - Event mode counts selected pin edges; match interrupts and clears.
// - Window mode counts internal clock gated by pin; match clears.
// - Window gate active level chosen by the edge select bit.
// - Pulse mode starts on selected edge with internal clock.
// - Opposite edge copies count to capture and interrupts.
// - Bit six picks single or double edge; single clears after capture.
// - Double edge keeps running, next trigger edge captures period.
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"
module timer_counter
  import timer_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // External pulse source
  input  wire logic        timer_input_pin_in,
  // Interrupt request
  output logic             counter_irq_out
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ahb_req_t    ph_q;
  ctrl_t       ctrl_q;
  logic        edge_sel_q;
  logic [15:0] compare_q;
  logic [15:0] capture_q;
  logic [15:0] count_q;
  logic        going_q;
  meas_t       meas_q;
  logic        irq_q;
  logic        addr_ok;
  logic        wr_ctrl;
  logic        wr_ext;
  logic        wr_cmp;
  logic        soft_cap;
  logic [31:0] rd_val;
  logic        tick;
  logic        pin_lvl;
  logic        pin_rise;
  logic        pin_fall;
  logic        trig_edge;
  logic        opp_edge;
  logic        gate_on;
  logic        match;
  logic [15:0] count_inc;
  mode_t       mode;
  logic        mode_chg;
  logic        cap_first;
  logic        cap_period;
  logic [31:0] stat_val;

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------

  // Only whole-word transfers to this slave are taken
  assign addr_ok = hsel_in & hready_in & htrans_in[1] & (hsize_in == 3'b010);

  // Address phase latched for the data phase
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ph_q <= '0;
    end else if (ce_in) begin
      ph_q.valid <= addr_ok;
      ph_q.wr    <= hwrite_in;
      ph_q.addr  <= haddr_in[7:0];
    end
  end

  // Write strobes in the data phase
  assign wr_ctrl = ph_q.valid & ph_q.wr & (ph_q.addr == `ADDR_CTRL);
  assign wr_ext  = ph_q.valid & ph_q.wr & (ph_q.addr == `ADDR_EXT_CTRL);
  assign wr_cmp  = ph_q.valid & ph_q.wr & (ph_q.addr == `ADDR_COMPARE);

  // Status word: run flag, pulse phase, filtered pin, live count
  assign stat_val = {12'h0, going_q, meas_q, pin_lvl, count_q};

  // Read multiplexer, unmapped reads as zero
  always_comb begin
    case (haddr_in[7:0])
      `ADDR_CTRL:     rd_val = {25'h0, ctrl_q};
      `ADDR_COMPARE:  rd_val = {16'h0, compare_q};
      `ADDR_CAPTURE:  rd_val = {16'h0, capture_q};
      `ADDR_EXT_CTRL: rd_val = {31'h0, edge_sel_q};
      `ADDR_STATUS:   rd_val = stat_val;
      default:        rd_val = 32'h0;
    endcase
  end

  // Read data registered at the address phase
  // A read right behind a write to the same register sees the old value
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      hrdata_out <= 32'h0;
    end else if (ce_in && addr_ok && !hwrite_in) begin
      hrdata_out <= rd_val;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // ----------------------------------------
  // Registers
  // ----------------------------------------

  // Soft capture only outside the pulse and external trigger modes
  assign soft_cap = wr_ctrl & hwdata_in[`CTRL_BIT6]
                  & (hwdata_in[2:0] != MODE_PULSE)
                  & (hwdata_in[2:0] != MODE_EXTTRIG);

  // A control write that changes the mode drops any half-done run
  assign mode_chg = wr_ctrl & (hwdata_in[2:0] != ctrl_q.mode);

  // Control register; capture request bit clears itself
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ctrl_q <= `CTRL_RST;
    end else if (ce_in && wr_ctrl) begin
      ctrl_q      <= hwdata_in[`CTRL_WIDTH-1:0];
      ctrl_q.bit6 <= hwdata_in[`CTRL_BIT6] & ~soft_cap;
    end
  end

  // Edge select for the trigger edge and the window gate level
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      edge_sel_q <= `EXT_RST;
    end else if (ce_in && wr_ext) begin
      edge_sel_q <= hwdata_in[`EXT_EDGE_BIT];
    end
  end

  // Compare register, no reset
  always_ff @(posedge mclk_in) begin
    if (ce_in && wr_cmp) begin
      compare_q <= hwdata_in[15:0];
    end
  end

  assign mode = mode_t'(ctrl_q.mode);

  // ----------------------------------------
  // Clock source and pin conditioning
  // ----------------------------------------

  // Selected internal count tick
  // Divider runs from reset, so a first period after start may be short
  count_prescaler u_presc (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .ce_in    (ce_in),
    .sel_in   (ctrl_q.clk_sel),
    .tick_out (tick)
  );

  // Filtered timer input
  pin_filter u_filt (
    .mclk_in   (mclk_in),
    .reset_in  (reset_in),
    .ce_in     (ce_in),
    .pin_in    (timer_input_pin_in),
    .level_out (pin_lvl),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  // Edge and level selection, 0 rising/high, 1 falling/low
  assign trig_edge = edge_sel_q ? pin_fall : pin_rise;
  assign opp_edge  = edge_sel_q ? pin_rise : pin_fall;
  assign gate_on   = edge_sel_q ? ~pin_lvl : pin_lvl;

  // Compare and increment
  // A match at a count event wraps, so a period is compare plus one
  assign match     = (count_q == compare_q);
  assign count_inc = count_q + 16'h0001;

  // Pulse-mode capture events, dropped on a mode change
  assign cap_first  = ctrl_q.run & ~mode_chg & (mode == MODE_PULSE)
                    & (meas_q == MS_FIRST) & opp_edge;
  assign cap_period = ctrl_q.run & ~mode_chg & (mode == MODE_PULSE)
                    & (meas_q == MS_SECOND) & trig_edge;

  // ----------------------------------------
  // Counter core
  // ----------------------------------------

  // Count, run state and request per mode
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      count_q <= 16'h0000;
      going_q <= 1'b0;
      meas_q  <= MS_WAIT;
      irq_q   <= 1'b0;
    end else if (ce_in) begin
      irq_q <= 1'b0;
      if (!ctrl_q.run || mode_chg) begin
        going_q <= 1'b0;
        meas_q  <= MS_WAIT;
      end else begin
        case (mode)
          MODE_TIMER: begin
            if (tick) begin
              if (match) begin
                count_q <= 16'h0000;
                irq_q   <= 1'b1;
              end else begin
                count_q <= count_inc;
              end
            end
          end
          MODE_EXTTRIG: begin
            if (!going_q) begin
              if (trig_edge) begin
                going_q <= 1'b1;
                count_q <= 16'h0000;
              end
            end else if (tick) begin
              if (match) begin
                count_q <= 16'h0000;
                going_q <= 1'b0;
                irq_q   <= 1'b1;
              end else begin
                count_q <= count_inc;
              end
            end
          end
          MODE_EVENT: begin
            if (trig_edge) begin
              if (match) begin
                count_q <= 16'h0000;
                irq_q   <= 1'b1;
              end else begin
                count_q <= count_inc;
              end
            end
          end
          MODE_WINDOW: begin
            if (tick && gate_on) begin
              if (match) begin
                count_q <= 16'h0000;
                irq_q   <= 1'b1;
              end else begin
                count_q <= count_inc;
              end
            end
          end
          MODE_PULSE: begin
            case (meas_q)
              MS_WAIT: begin
                if (trig_edge) begin
                  count_q <= 16'h0000;
                  meas_q  <= MS_FIRST;
                end
              end
              MS_FIRST: begin
                // An edge wins over a tick in the same cycle
                if (opp_edge) begin
                  irq_q <= 1'b1;
                  if (!ctrl_q.bit6) begin
                    count_q <= 16'h0000;
                    meas_q  <= MS_WAIT;
                  end else begin
                    meas_q <= MS_SECOND;
                  end
                end else if (tick) begin
                  count_q <= count_inc;
                end
              end
              MS_SECOND: begin
                if (trig_edge) begin
                  irq_q   <= 1'b1;
                  count_q <= 16'h0000;
                  meas_q  <= MS_FIRST;
                end else if (tick) begin
                  count_q <= count_inc;
                end
              end
              default: begin
                meas_q <= MS_WAIT;
              end
            endcase
          end
          // Unused mode codes leave the count alone
          default: begin
            going_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Capture register
  // ----------------------------------------

  // Capture register, no reset; soft copy or edge capture
  always_ff @(posedge mclk_in) begin
    if (ce_in) begin
      if (soft_cap) begin
        capture_q <= count_q;
      end else if (cap_first) begin
        capture_q <= count_q;
      end else if (cap_period) begin
        capture_q <= count_q;
      end
    end
  end

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------

  // One-cycle request, from a flip-flop
  assign counter_irq_out = irq_q;

endmodule
`default_nettype wire

// File: common/timer_consts.svh
// Offsets, field positions, reset values and timing counts of the timer
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADDR_CTRL      8'h00
`define ADDR_COMPARE   8'h04
`define ADDR_CAPTURE   8'h08
`define ADDR_EXT_CTRL  8'h0c
`define ADDR_STATUS    8'h10
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_MODE_LSB  0
`define CTRL_CLK_LSB   3
`define CTRL_RUN_BIT   5
`define CTRL_BIT6      6
`define CTRL_WIDTH     7
`define CTRL_RST       7'h00
`define EXT_EDGE_BIT   0
`define EXT_RST        1'b0
// ----------------------------------------
// Prescaler taps: divide by 8, 128, 2048
// ----------------------------------------
`define TAP_DIV8       3
`define TAP_DIV128     7
`define TAP_DIV2048    11
`define PRESC_WIDTH    11
// ----------------------------------------
// Noise filter: pulses up to 7 oscillator periods dropped
// ----------------------------------------
`define NOISE_REJ_FC   7
`define NOISE_CYC      (`NOISE_REJ_FC + 1)
`define NOISE_CNT_W    4
`endif

// File: common/timer_pkg.sv
// Types shared by the timer/counter design files
package timer_pkg;
  // Counter operating modes
  typedef enum logic [2:0] {
    MODE_TIMER   = 3'b000,
    MODE_EXTTRIG = 3'b001,
    MODE_EVENT   = 3'b010,
    MODE_WINDOW  = 3'b011,
    MODE_PULSE   = 3'b100
  } mode_t;
  // Pulse measurement phases
  typedef enum logic [1:0] {
    MS_WAIT   = 2'b00,
    MS_FIRST  = 2'b01,
    MS_SECOND = 2'b10
  } meas_t;
  // Control register layout
  typedef struct packed {
    logic       bit6;
    logic       run;
    logic [1:0] clk_sel;
    logic [2:0] mode;
  } ctrl_t;
  // Latched AHB address phase
  typedef struct packed {
    logic       valid;
    logic       wr;
    logic [7:0] addr;
  } ahb_req_t;
endpackage

// File: design/count_prescaler.sv
// Oscillator prescaler giving one count tick per selected tap
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"
module count_prescaler (
  // Clock, reset, enable
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  input  wire logic       ce_in,
  // Tap select and tick
  input  wire logic [1:0] sel_in,
  output logic            tick_out
);
  logic [`PRESC_WIDTH-1:0] div_q;
  logic [`PRESC_WIDTH-1:0] mask;
  // Tap mask: all ones below the divide point
  always_comb begin
    case (sel_in)
      2'b00:   mask = 11'((1 << `TAP_DIV8) - 1);
      2'b01:   mask = 11'((1 << `TAP_DIV128) - 1);
      default: mask = 11'((1 << `TAP_DIV2048) - 1);
    endcase
  end
  // Free running divider
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      div_q <= 11'h000;
    end else if (ce_in) begin
      div_q <= div_q + 11'h001;
    end
  end
  // One-cycle tick at each tap period
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      tick_out <= 1'b0;
    end else if (ce_in) begin
      tick_out <= ((div_q & mask) == mask);
    end
  end
endmodule
`default_nettype wire

// File: design/pin_filter.sv
// Pin synchroniser, noise filter and edge detector
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"
module pin_filter (
  // Clock, reset, enable
  input  wire logic mclk_in,
  input  wire logic reset_in,
  input  wire logic ce_in,
  // Raw pin
  input  wire logic pin_in,
  // Filtered level and edges
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic                    s1_q;
  logic                    s2_q;
  logic [`NOISE_CNT_W-1:0] cnt_q;
  // Two-stage synchroniser
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else if (ce_in) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
    end
  end
  // Level accepted only after it stays put past the reject width
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cnt_q     <= 4'h0;
      level_out <= 1'b0;
      rise_out  <= 1'b0;
      fall_out  <= 1'b0;
    end else if (ce_in) begin
      rise_out <= 1'b0;
      fall_out <= 1'b0;
      if (s2_q == level_out) begin
        cnt_q <= 4'h0;
      end else if (cnt_q == 4'(`NOISE_CYC - 1)) begin
        cnt_q     <= 4'h0;
        level_out <= s2_q;
        rise_out  <= s2_q;
        fall_out  <= ~s2_q;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/timer_counter_chk.sv
// Bus and interrupt checker for the timer/counter
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"
module timer_counter_chk (
  // Clock, reset, enable
  input wire logic        mclk_in,
  input wire logic        reset_in,
  input wire logic        ce_in,
  // Bus
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [2:0]  hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  // Pin and interrupt
  input wire logic        timer_input_pin_in,
  input wire logic        counter_irq_out
);
  // Word read taken at this edge
  wire logic rd = hsel_in & hready_in & htrans_in[1] & ~hwrite_in & (hsize_in == 3'b010) & ce_in;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_ready;
    hreadyout_out == 1'b1;
  endproperty
  property p_okay;
    hresp_out == 1'b0;
  endproperty
  property p_irq_pulse;
    counter_irq_out |=> !counter_irq_out;
  endproperty
  property p_rst_out;
    $fell(reset_in) |-> !counter_irq_out && hrdata_out == 32'h0;
  endproperty
  property p_unmapped;
    rd && haddr_in[7:0] == 8'h14 |=> hrdata_out == 32'h0;
  endproperty
  property p_status_hi;
    rd && haddr_in[7:0] == `ADDR_STATUS |=> hrdata_out[31:20] == 12'h0;
  endproperty
  property p_cmp_hi;
    rd && haddr_in[7:0] == `ADDR_COMPARE |=> hrdata_out[31:16] == 16'h0;
  endproperty
  property p_cap_hi;
    rd && haddr_in[7:0] == `ADDR_CAPTURE |=> hrdata_out[31:16] == 16'h0;
  endproperty
  property p_hold;
    !rd |=> $stable(hrdata_out);
  endproperty
  property p_soft_clr;
    rd && haddr_in[7:0] == `ADDR_CTRL |=>
      (!hrdata_out[6] || hrdata_out[2:0] == 3'b001 || hrdata_out[2:0] == 3'b100);
  endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  a_okay: assert property (p_okay) else $error("hresp not okay");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_status_hi: assert property (p_status_hi) else $error("status upper bits set");
  a_cmp_hi: assert property (p_cmp_hi) else $error("compare wider than 16 bits");
  a_cap_hi: assert property (p_cap_hi) else $error("capture wider than 16 bits");
  a_hold: assert property (p_hold) else $error("read data changed without read");
  a_soft_clr: assert property (p_soft_clr) else $error("soft capture bit not cleared");
  // Main scenarios reached
  c_irq: cover property (counter_irq_out);
  c_read: cover property (rd);
  c_rst: cover property ($fell(reset_in));
endmodule
bind timer_counter timer_counter_chk chk (.mclk_in(mclk_in), .reset_in(reset_in),
  .ce_in(ce_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
  .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .timer_input_pin_in(timer_input_pin_in),
  .counter_irq_out(counter_irq_out));
`default_nettype wire

// File: verification/pulse_src.sv
// External pulse source driving the timer input pin
`timescale 1ns/1ps
`default_nettype none
module pulse_src (
  // Clock
  input  wire logic mclk_in,
  // Driven pin
  output logic      pin_out
);
  // Pin idles low between pulses
  initial pin_out = 1'b0;
  // Hold a level for a number of cycles
  task automatic drive_level(input logic lvl, input int n);
    pin_out <= lvl;
    repeat (n) @(posedge mclk_in);
  endtask
  // One pulse, normally 24 cycles or more per level
  task automatic pulse(input int hi, input int lo);
    drive_level(1'b1, hi);
    drive_level(1'b0, lo);
  endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the timer/counter
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] cmp;
    logic [31:0] per;
  } row_t;
  logic        mclk_in;
  logic        reset_in;
  logic        ce;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        pin;
  logic        irq;
  int          n_fail;
  int          tests_run;
  int          n_irq;
  int          cyc;
  logic [31:0] v;
  logic [31:0] s;
  logic [31:0] t;
  row_t        rows [4] = '{'{32'h20, 32'h3, 32'h20}, '{32'h28, 32'h1, 32'h100},
                            '{32'h30, 32'h0, 32'h800}, '{32'h38, 32'h0, 32'h800}};
  // Design and pin source
  timer_counter dut (.mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce), .hsel_in(1'b1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .timer_input_pin_in(pin), .counter_irq_out(irq));
  pulse_src src (.mclk_in(mclk_in), .pin_out(pin));
  // Clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // Interrupt count and hang guard
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) n_irq <= n_irq + 1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      results();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge mclk_in); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk_in); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, t);
  endtask
  task rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0, v);
  endtask
  task rst;
    reset_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task wait_irq(output logic [31:0] n);
    n = 0;
    do begin
      @(posedge mclk_in);
      n = n + 1;
    end while (irq !== 1'b1 && n < 5000);
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  task chk_rng(input string name, input logic [31:0] lo, hi, got);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_fail++;
      $display("BAD %s exp %h..%h got %h", name, lo, hi, got);
    end
  endtask
  task results;
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    ce = 1'b1;
    reset_in = 1'b1;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    n_fail = 0;
    tests_run = 0;
    n_irq = 0;
    cyc = 0;
    repeat (20) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    // Reset values, unmapped place, compare kept over reset
    rd(`ADDR_CTRL);
    chk("ctrl_rst", 32'h0, v);
    rd(`ADDR_EXT_CTRL);
    chk("edge_rst", 32'h0, v);
    rd(8'h14);
    chk("unmapped", 32'h0, v);
    wr(`ADDR_COMPARE, 32'hffff1234);
    rst();
    rd(`ADDR_COMPARE);
    chk("cmp_keep", 32'h1234, v);
    // Timer period for every tap
    foreach (rows[i]) begin
      rst();
      wr(`ADDR_COMPARE, rows[i].cmp);
      wr(`ADDR_CTRL, rows[i].ctrl);
      wait_irq(t);
      wait_irq(t);
      chk("timer_period", rows[i].per, t);
    end
    // Event counting, glitch and frozen edge dropped, soft capture, wrap
    rst();
    wr(`ADDR_COMPARE, 32'h3);
    wr(`ADDR_CTRL, 32'h22);
    repeat (3) src.pulse(30, 30);
    src.pulse(7, 30);
    ce <= 1'b0;
    src.pulse(30, 30);
    ce <= 1'b1;
    rd(`ADDR_STATUS);
    chk("event_cnt", 32'h3, {16'h0, v[15:0]});
    wr(`ADDR_CTRL, 32'h62);
    rd(`ADDR_CAPTURE);
    chk("soft_cap", 32'h3, v);
    rd(`ADDR_CTRL);
    chk("cap_bit_clr", 32'h22, v);
    s = n_irq;
    src.pulse(30, 30);
    chk("event_irq", s + 1, n_irq);
    rd(`ADDR_STATUS);
    chk("event_wrap", 32'h0, {16'h0, v[15:0]});
    // External trigger start, match halts
    rst();
    wr(`ADDR_COMPARE, 32'h4);
    wr(`ADDR_CTRL, 32'h21);
    rd(`ADDR_STATUS);
    chk("trig_idle", 32'h0, {12'h0, v[19:0]});
    s = n_irq;
    src.drive_level(1'b1, 20);
    rd(`ADDR_STATUS);
    chk("trig_run", 32'h1, {31'h0, v[19]});
    src.drive_level(1'b0, 80);
    rd(`ADDR_STATUS);
    chk("trig_halt", 32'h0, {12'h0, v[19:0]});
    chk("trig_irq", s + 1, n_irq);
    src.pulse(30, 60);
    chk("trig_again", s + 2, n_irq);
    // Pulse width, single then double edge
    rst();
    wr(`ADDR_COMPARE, 32'hffff);
    wr(`ADDR_CTRL, 32'h24);
    s = n_irq;
    src.pulse(80, 40);
    rd(`ADDR_CAPTURE);
    chk_rng("width_single", 32'h9, 32'hb, v);
    rd(`ADDR_STATUS);
    chk("single_back", 32'h0, {14'h0, v[18:17], v[15:0]});
    wr(`ADDR_CTRL, 32'h64);
    src.pulse(80, 40);
    rd(`ADDR_CAPTURE);
    chk_rng("width_dbl", 32'h9, 32'hb, v);
    src.drive_level(1'b0, 38);
    src.drive_level(1'b1, 20);
    rd(`ADDR_CAPTURE);
    chk_rng("period_dbl", 32'h13, 32'h15, v);
    chk("pulse_irq", s + 3, n_irq);
    // Capture kept over reset
    s = v;
    rst();
    rd(`ADDR_CAPTURE);
    chk("cap_keep", s, v);
    // Window gate, high then low polarity, then unused mode holds the count
    wr(`ADDR_COMPARE, 32'hffff);
    wr(`ADDR_CTRL, 32'h23);
    src.pulse(160, 40);
    rd(`ADDR_STATUS);
    chk_rng("win_high", 32'h13, 32'h15, {16'h0, v[15:0]});
    wr(`ADDR_EXT_CTRL, 32'h1);
    rd(`ADDR_STATUS);
    s = {16'h0, v[15:0]};
    src.drive_level(1'b0, 160);
    rd(`ADDR_STATUS);
    chk_rng("win_low", s + 32'h13, s + 32'h15, {16'h0, v[15:0]});
    s = {16'h0, v[15:0]};
    wr(`ADDR_CTRL, 32'h25);
    src.drive_level(1'b0, 40);
    rd(`ADDR_STATUS);
    chk_rng("idle_mode", s, s + 32'h1, {16'h0, v[15:0]});
    results();
  end
endmodule
`default_nettype wire
